// ---- rtl/slb_link_top.sv ----
// Data-link bring-up, lane status and sync-request logic
//
// Operation
// RULE_01: Two multiframe delay bytes, host writes zero
// RULE_02: Two rx buffer delay bytes, written ten
// RULE_03: Control low bit selects one-shot alignment
// RULE_04: Control bit 7 enables alignment machine
// RULE_05: Control bit 6 arms; waits SYSREF edge
// RULE_06: Source sends SYSREF edge before link enable
// RULE_07: Link bits: enables, page select, dual
// RULE_08: Lane bit set after four K28.5
// RULE_09: Frame sync status, one bit per lane
// RULE_10: Checksum good status, one bit per lane
// RULE_11: Transmitter sends ILAS; status bit per lane
// RULE_12: Page bit shows lanes four to seven
// RULE_13: No deterministic latency promised here
// RULE_14: Sync request high when link lanes synced
// RULE_15: Sync request driven glitch-free from flops
`timescale 1ns/100ps
module slb_link_top #(
  parameter int unsigned K_RUN = slb_pkg::K285_RUN,
  parameter int unsigned LPL   = slb_pkg::LANES_PER_LINK
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [15:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Deserialised lanes, same clock
  input  wire logic [7:0]  serial_lane_input_valid_i,
  input  wire logic [7:0]  serial_lane_input_k285_i,
  input  wire logic [7:0]  serial_lane_input_err_i,
  input  wire logic [7:0]  serial_lane_input_frame_i,
  input  wire logic [7:0]  serial_lane_input_cksum_i,
  input  wire logic [7:0]  serial_lane_input_ilas_i,
  // SYSREF pin, asynchronous
  input  wire logic        sysref_i,
  // Sync requests and interrupt
  output logic             link0_sync_request_out_o,
  output logic             link1_sync_request_out_o,
  output logic             irq_o
);
  import slb_pkg::*;

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  // Status registers carry four lanes per link in their low nibble
  if (LPL != 4) begin : g_chk
    $error("LPL must be 4");
  end

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [7:0]      sync_ctrl_ff;  // Alignment control
  logic [7:0]      link_ctl_ff;   // Link enables and page
  logic [7:0]      subclass_ff;   // Subclass select
  logic [7:0]      mf_dly_a_ff;   // Multiframe delay, low
  logic [7:0]      mf_dly_b_ff;   // Multiframe delay, high
  logic [7:0]      rxb_dly_a_ff;  // Rx buffer delay, low
  logic [7:0]      rxb_dly_b_ff;  // Rx buffer delay, high
  logic [4:0]      irq_stat_ff;   // Sticky events
  logic [4:0]      irq_mask_ff;   // Event mask
  logic [4:0]      nxt_irq_stat;  // Next sticky events
  logic [4:0]      irq_evt;       // Events this cycle
  logic [7:0]      frm_stat_ff;   // Frame sync per lane
  logic [7:0]      cks_stat_ff;   // Checksum good per lane
  logic [7:0]      ilas_stat_ff;  // ILAS seen per lane
  logic [7:0]      cgs_ok;        // Code-group sync per lane
  logic [1:0]      link_all_ok;   // All lanes of link synced
  logic [1:0]      link_ok_q_ff;  // Previous link_all_ok
  logic [1:0]      link_en;       // Effective link enables
  logic [2:0]      sysref_sy_ff;  // Pin synchroniser
  logic            sysref_lvl_ff; // Agreed SYSREF level
  logic            sysref_edge;   // Qualified rising edge
  logic            aligned;       // Alignment event
  slb_sync_state_e sync_state;    // Machine state
  logic            req;           // Bus request pending
  logic            wr_take;       // Write taken this edge
  logic            rd_take;       // Read taken this edge
  slb_idx_t        idx;           // Register index
  logic [7:0]      wr_byte;       // Write data, lane 0
  logic [7:0]      nxt_rd;        // Read mux
  logic [3:0]      sel_cgs;       // Page view of sync status

  // ****************************************************************
  // Wishbone decode
  // ****************************************************************
  assign req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign idx     = wb_adr_i[13:2];
  assign wr_byte = wb_dat_i[7:0];
  // Only byte lane 0 holds data; upper lanes are ignored
  assign wr_take = req && wb_we_i && wb_sel_i[0];
  assign rd_take = req && !wb_we_i;

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) wb_ack_o <= 1'b0;
    else       wb_ack_o <= req;
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  // Plain byte registers with no side effects
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      subclass_ff  <= RST_BYTE;
      mf_dly_a_ff  <= RST_BYTE;
      mf_dly_b_ff  <= RST_BYTE;
      rxb_dly_a_ff <= RST_BYTE;
      rxb_dly_b_ff <= RST_BYTE;
      irq_mask_ff  <= RST_IRQ;
    end else if (wr_take) begin
      unique case (idx)
        IDX_SUBCLASS:  subclass_ff  <= wr_byte;
        IDX_MF_DLY_A:  mf_dly_a_ff  <= wr_byte; // RULE_01
        IDX_MF_DLY_B:  mf_dly_b_ff  <= wr_byte; // RULE_01
        IDX_RXB_DLY_A: rxb_dly_a_ff <= wr_byte; // RULE_02
        IDX_RXB_DLY_B: rxb_dly_b_ff <= wr_byte; // RULE_02
        IDX_IRQ_MASK:  irq_mask_ff  <= wr_byte[4:0];
        default: ;
      endcase
    end
  end

  // Link enables, dual-link and page select
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_ctl_ff <= RST_BYTE;
    end else if (wr_take && idx == IDX_LINK_CTL) begin
      link_ctl_ff <= wr_byte; // RULE_07
    end
  end

  // Sync control; arm self-clears when the one-shot completes.
  // A write in the same cycle wins so software is never overruled.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_ctrl_ff <= RST_BYTE;
    end else if (wr_take && idx == IDX_SYNC_CTRL) begin
      sync_ctrl_ff <= wr_byte; // RULE_03 RULE_04 RULE_05
    end else if (aligned) begin
      sync_ctrl_ff[SYNC_ARM_BIT] <= 1'b0;
    end
  end

  // ****************************************************************
  // SYSREF pin capture
  // ****************************************************************
  // Three flops; a level counts once the last two agree
  always_ff @(posedge clk_i) begin
    if (rst_i) sysref_sy_ff <= 3'h0;
    else       sysref_sy_ff <= {sysref_sy_ff[1:0], sysref_i};
  end

  // Agreed level, immune to a single metastable sample
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sysref_lvl_ff <= 1'b0;
    end else if (sysref_sy_ff[1] == sysref_sy_ff[2]) begin
      sysref_lvl_ff <= sysref_sy_ff[2];
    end
  end

  assign sysref_edge = sysref_sy_ff[1] && sysref_sy_ff[2]
                       && !sysref_lvl_ff;

  // ****************************************************************
  // Alignment machine
  // ****************************************************************
  // The one-shot only marks the multiframe phase; the delay bytes
  // are held for the datapath and no fixed latency is implied.
  slb_sync_fsm u_sync (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .mode_i        (sync_ctrl_ff[SYNC_MODE_BIT]),
    .enable_i      (sync_ctrl_ff[SYNC_EN_BIT]),
    .arm_i         (sync_ctrl_ff[SYNC_ARM_BIT]),
    .sysref_edge_i (sysref_edge),
    .state_o       (sync_state),
    .aligned_o     (aligned)
  ); // RULE_13

  // ****************************************************************
  // Lanes
  // ****************************************************************
  // Link 1 runs only in dual-link mode
  assign link_en[0] = link_ctl_ff[LINK0_EN_BIT]; // RULE_07
  assign link_en[1] = link_ctl_ff[LINK1_EN_BIT]
                      && link_ctl_ff[DUAL_BIT];

  // One detector per lane, lanes 0-3 on link 0, 4-7 on link 1
  for (genvar g = 0; g < 8; g++) begin : g_lane
    slb_lane_cgs #(
      .RUN (K_RUN)
    ) u_cgs (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .link_en_i    (link_en[g / 4]),
      .char_valid_i (serial_lane_input_valid_i[g]),
      .k285_i       (serial_lane_input_k285_i[g]),
      .code_err_i   (serial_lane_input_err_i[g]),
      .cgs_ok_o     (cgs_ok[g])
    ); // RULE_08
  end

  assign link_all_ok[0] = &cgs_ok[3:0];
  assign link_all_ok[1] = &cgs_ok[7:4];

  // Per-lane status; meaningless before the lane has CGS
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frm_stat_ff  <= RST_BYTE;
      cks_stat_ff  <= RST_BYTE;
      ilas_stat_ff <= RST_BYTE;
    end else begin
      frm_stat_ff  <= serial_lane_input_frame_i & cgs_ok; // RULE_09
      cks_stat_ff  <= serial_lane_input_cksum_i & cgs_ok; // RULE_10
      ilas_stat_ff <= serial_lane_input_ilas_i & cgs_ok;  // RULE_11
    end
  end

  // ****************************************************************
  // Sync requests
  // ****************************************************************
  // Registered so the pins never glitch; a glitch would be taken
  // by the transmitter as a request for K characters.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link0_sync_request_out_o <= 1'b0;
      link1_sync_request_out_o <= 1'b0;
    end else begin
      link0_sync_request_out_o <= link_en[0] && link_all_ok[0]; // RULE_14 RULE_15
      link1_sync_request_out_o <= link_en[1] && link_all_ok[1]; // RULE_14 RULE_15
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  // Previous all-lane state for gain and loss edges
  always_ff @(posedge clk_i) begin
    if (rst_i) link_ok_q_ff <= 2'h0;
    else       link_ok_q_ff <= link_all_ok;
  end

  always_comb begin
    irq_evt            = 5'h00;
    irq_evt[IRQ_CGS0]  = link_all_ok[0] && !link_ok_q_ff[0];
    irq_evt[IRQ_CGS1]  = link_all_ok[1] && !link_ok_q_ff[1];
    irq_evt[IRQ_LOST0] = !link_all_ok[0] && link_ok_q_ff[0];
    irq_evt[IRQ_LOST1] = !link_all_ok[1] && link_ok_q_ff[1];
    irq_evt[IRQ_ALIGN] = aligned;
  end

  // Read clears; an event in the clearing cycle survives
  always_comb begin
    nxt_irq_stat = irq_stat_ff;
    if (rd_take && idx == IDX_IRQ_STAT) nxt_irq_stat = 5'h00;
    nxt_irq_stat = nxt_irq_stat | irq_evt;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) irq_stat_ff <= RST_IRQ;
    else       irq_stat_ff <= nxt_irq_stat;
  end

  // Level output, follows the stored state
  always_ff @(posedge clk_i) begin
    if (rst_i) irq_o <= 1'b0;
    else       irq_o <= |(irq_stat_ff & irq_mask_ff);
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Page bit picks which link's four lanes appear
  assign sel_cgs = link_ctl_ff[PAGE_BIT] ? cgs_ok[7:4]
                                         : cgs_ok[3:0]; // RULE_12

  always_comb begin
    nxt_rd = 8'h00; // Unmapped reads return zero
    unique case (idx)
      IDX_IRQ_STAT:  nxt_rd = {3'h0, irq_stat_ff};
      IDX_IRQ_MASK:  nxt_rd = {3'h0, irq_mask_ff};
      IDX_SYNC_CTRL: nxt_rd = sync_ctrl_ff;
      IDX_SYNC_STAT: nxt_rd = {4'h0, sync_state};
      IDX_LINK_CTL:  nxt_rd = link_ctl_ff;
      IDX_SUBCLASS:  nxt_rd = subclass_ff;
      IDX_MF_DLY_A:  nxt_rd = mf_dly_a_ff;
      IDX_MF_DLY_B:  nxt_rd = mf_dly_b_ff;
      IDX_RXB_DLY_A: nxt_rd = rxb_dly_a_ff;
      IDX_RXB_DLY_B: nxt_rd = rxb_dly_b_ff;
      IDX_CGS_STAT:  nxt_rd = {4'h0, sel_cgs};
      IDX_FRM_STAT:  nxt_rd = {4'h0, link_ctl_ff[PAGE_BIT] ?
                       frm_stat_ff[7:4] : frm_stat_ff[3:0]};
      IDX_CKS_STAT:  nxt_rd = {4'h0, link_ctl_ff[PAGE_BIT] ?
                       cks_stat_ff[7:4] : cks_stat_ff[3:0]};
      IDX_ILAS_STAT: nxt_rd = {4'h0, link_ctl_ff[PAGE_BIT] ?
                       ilas_stat_ff[7:4] : ilas_stat_ff[3:0]};
      default:       nxt_rd = 8'h00;
    endcase
  end

  // Data registered with ack, zero between reads
  always_ff @(posedge clk_i) begin
    if (rst_i || !rd_take) wb_dat_o <= 32'h0000_0000;
    else                   wb_dat_o <= {24'h00_0000, nxt_rd};
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  AST_ACK_ONE_CYCLE: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  AST_LINK_CTL_WRITE: assert property ( // RULE_07
    @(posedge clk_i) disable iff (rst_i)
    (wr_take && idx == IDX_LINK_CTL) |=> link_ctl_ff == $past(wr_byte))
    else $error("link control write lost");

  AST_MF_DELAY_WRITE: assert property ( // RULE_01
    @(posedge clk_i) disable iff (rst_i)
    (wr_take && idx == IDX_MF_DLY_A) |=> mf_dly_a_ff == $past(wr_byte))
    else $error("multiframe delay write lost");

  AST_RXB_DELAY_WRITE: assert property ( // RULE_02
    @(posedge clk_i) disable iff (rst_i)
    (wr_take && idx == IDX_RXB_DLY_B) |=> rxb_dly_b_ff == $past(wr_byte))
    else $error("rx buffer delay write lost");

  AST_PAGE_VIEW: assert property ( // RULE_12
    @(posedge clk_i) disable iff (rst_i)
    (rd_take && idx == IDX_CGS_STAT) |=>
      (wb_ack_o && wb_dat_o[3:0] == $past(sel_cgs)))
    else $error("code-group sync read wrong page");

  AST_SYNC_REQ_HIGH: assert property ( // RULE_14
    @(posedge clk_i) disable iff (rst_i)
    (link_en[0] && link_all_ok[0]) |=> link0_sync_request_out_o)
    else $error("link 0 sync request not raised");

  AST_SYNC_REQ_LOW: assert property ( // RULE_14
    @(posedge clk_i) disable iff (rst_i)
    !(link_en[1] && link_all_ok[1]) |=> !link1_sync_request_out_o)
    else $error("link 1 sync request high without sync");

  AST_IRQ_LEVEL: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ##1 irq_o == $past(|(irq_stat_ff & irq_mask_ff)))
    else $error("interrupt does not follow masked status");

endmodule

// ---- inc/slb_pkg.sv ----
// Constants and types of the serial link bring-up block
package slb_pkg;

  // ****************************************************************
  // Register indexes (byte address is four times the index)
  // ****************************************************************
  typedef logic [11:0] slb_idx_t;
  localparam slb_idx_t IDX_IRQ_STAT  = 12'h010; // Sticky events
  localparam slb_idx_t IDX_IRQ_MASK  = 12'h011; // Event mask
  localparam slb_idx_t IDX_SYNC_CTRL = 12'h03A; // Sync machine control
  localparam slb_idx_t IDX_SYNC_STAT = 12'h03B; // Sync machine state
  localparam slb_idx_t IDX_LINK_CTL  = 12'h300; // Link enable, page
  localparam slb_idx_t IDX_SUBCLASS  = 12'h301; // Subclass select
  localparam slb_idx_t IDX_MF_DLY_A  = 12'h304; // Multiframe delay
  localparam slb_idx_t IDX_MF_DLY_B  = 12'h305;
  localparam slb_idx_t IDX_RXB_DLY_A = 12'h306; // Rx buffer delay
  localparam slb_idx_t IDX_RXB_DLY_B = 12'h307;
  localparam slb_idx_t IDX_CGS_STAT  = 12'h470; // Code-group sync
  localparam slb_idx_t IDX_FRM_STAT  = 12'h471; // Frame sync
  localparam slb_idx_t IDX_CKS_STAT  = 12'h472; // Checksum good
  localparam slb_idx_t IDX_ILAS_STAT = 12'h473; // Lane alignment seq

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [4:0] RST_IRQ  = 5'h00;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned SYNC_MODE_BIT = 0; // One-shot mode
  localparam int unsigned SYNC_ARM_BIT  = 6; // Arm
  localparam int unsigned SYNC_EN_BIT   = 7; // Enable machine
  localparam int unsigned LINK0_EN_BIT  = 0;
  localparam int unsigned LINK1_EN_BIT  = 1;
  localparam int unsigned PAGE_BIT      = 2; // 1 selects link 1
  localparam int unsigned DUAL_BIT      = 3;
  localparam int unsigned IRQ_CGS0      = 0; // Link 0 sync gained
  localparam int unsigned IRQ_CGS1      = 1; // Link 1 sync gained
  localparam int unsigned IRQ_LOST0     = 2; // Link 0 sync lost
  localparam int unsigned IRQ_LOST1     = 3; // Link 1 sync lost
  localparam int unsigned IRQ_ALIGN     = 4; // SYSREF alignment done

  // ****************************************************************
  // Counts
  // ****************************************************************
  localparam int unsigned K285_RUN       = 4; // Consecutive K28.5
  localparam int unsigned LANES_PER_LINK = 4;

  // ****************************************************************
  // Alignment machine states
  // ****************************************************************
  typedef enum logic [3:0] {
    SLB_OFF   = 4'b0001,
    SLB_IDLE  = 4'b0010,
    SLB_ARMED = 4'b0100,
    SLB_DONE  = 4'b1000
  } slb_sync_state_e;

endpackage

// ---- rtl/slb_lane_cgs.sv ----
// Per-lane code-group sync detector
`timescale 1ns/100ps
module slb_lane_cgs #(
  parameter int unsigned RUN = slb_pkg::K285_RUN
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Lane character stream
  input  wire logic link_en_i,
  input  wire logic char_valid_i,
  input  wire logic k285_i,
  input  wire logic code_err_i,
  // Result
  output logic      cgs_ok_o
);
  import slb_pkg::*;

  logic [2:0] run_ff; // Consecutive K28.5 seen so far

  // Counter is three bits wide
  if (RUN < 1 || RUN > 7) begin : g_chk
    $error("RUN must be 1 to 7");
  end

  // Run counter; any other character restarts the run
  always_ff @(posedge clk_i) begin
    if (rst_i || !link_en_i || code_err_i) begin
      run_ff <= 3'h0;
    end else if (char_valid_i) begin
      if (!k285_i) begin
        run_ff <= 3'h0;
      end else if (run_ff != 3'(RUN)) begin
        run_ff <= run_ff + 3'h1;
      end
    end
  end

  // Sync holds through ILAS and data until an error or disable
  always_ff @(posedge clk_i) begin
    if (rst_i || !link_en_i || code_err_i) begin
      cgs_ok_o <= 1'b0;
    end else if (char_valid_i && k285_i && run_ff >= 3'(RUN - 1)) begin
      cgs_ok_o <= 1'b1; // RULE_08
    end
  end

  AST_CGS_AFTER_RUN: assert property ( // RULE_08
    @(posedge clk_i) disable iff (rst_i)
    (link_en_i && char_valid_i && k285_i && !code_err_i)[*4]
      ##1 (link_en_i && !code_err_i) |-> cgs_ok_o)
    else $error("lane sync missing after four K28.5");

endmodule

// ---- rtl/slb_sync_fsm.sv ----
// One-shot SYSREF alignment machine
`timescale 1ns/100ps
module slb_sync_fsm (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // Control bits
  input  wire logic               mode_i,
  input  wire logic               enable_i,
  input  wire logic               arm_i,
  // Qualified SYSREF rising edge
  input  wire logic               sysref_edge_i,
  // State and event
  output slb_pkg::slb_sync_state_e state_o,
  output logic                    aligned_o
);
  import slb_pkg::*;

  slb_sync_state_e nxt_state; // Next state
  logic            run_ok;    // Mode and enable both set

  assign run_ok = mode_i && enable_i;

  // Next-state logic
  always_comb begin
    nxt_state = state_o;
    unique case (state_o)
      SLB_OFF: begin
        if (run_ok) nxt_state = SLB_IDLE; // RULE_03 RULE_04
      end
      SLB_IDLE: begin
        if (!run_ok) nxt_state = SLB_OFF;
        else if (arm_i) nxt_state = SLB_ARMED; // RULE_05
      end
      SLB_ARMED: begin
        if (!run_ok) nxt_state = SLB_OFF;
        else if (!arm_i) nxt_state = SLB_IDLE;
        else if (sysref_edge_i) nxt_state = SLB_DONE; // RULE_05
      end
      SLB_DONE: begin
        // One-shot: later edges are ignored until re-enabled
        if (!run_ok) nxt_state = SLB_OFF;
      end
      default: nxt_state = SLB_OFF;
    endcase
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) state_o <= SLB_OFF;
    else       state_o <= nxt_state;
  end

  // Alignment event, one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) aligned_o <= 1'b0;
    else aligned_o <= state_o == SLB_ARMED && nxt_state == SLB_DONE;
  end

  AST_ALIGN_ON_EDGE: assert property ( // RULE_05
    @(posedge clk_i) disable iff (rst_i)
    (state_o == SLB_ARMED && run_ok && arm_i && sysref_edge_i)
      |=> (state_o == SLB_DONE && aligned_o))
    else $error("armed machine missed SYSREF edge");

  AST_ONE_SHOT: assert property ( // RULE_03
    @(posedge clk_i) disable iff (rst_i)
    (state_o == SLB_DONE && run_ok) |=> (state_o == SLB_DONE && !aligned_o))
    else $error("one-shot machine realigned");

endmodule

// ---- verif/slb_tx_model.sv ----
// Far-end lane transmitter and SYSREF source model
`timescale 1ns/100ps
module slb_tx_model (
  // Clock and commands from the bench
  input  wire logic       clk_i,
  input  wire logic       k_i,
  input  wire logic [7:0] good_i,
  input  wire logic       sref_i,
  // Lane and SYSREF drive
  output logic      [7:0] vld_o,
  output logic      [7:0] k285_o,
  output logic      [7:0] stat_o,
  output logic            sysref_o
);
  // ****************************************************************
  // Character stream
  // ****************************************************************
  // A character every cycle: K28.5 while asked, plain data otherwise
  always_ff @(posedge clk_i) begin
    vld_o  <= 8'hFF;
    k285_o <= {8{k_i}};
  end

  // Per-lane alignment results after ILAS and data
  always_ff @(posedge clk_i) begin
    stat_o <= good_i;
  end

  // SYSREF follows the bench one cycle later; the bench holds it six cycles so the synchroniser sees it
  always_ff @(posedge clk_i) begin
    sysref_o <= sref_i;
  end
endmodule

// ---- verif/tb_top.sv ----
// Self-checking bench of the link bring-up block
`timescale 1ns/100ps
module tb_top;
  import slb_pkg::*;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic        k = 0, sref = 0, ack, irq, sr0, sr1, sysref;
  logic [15:0] adr = 16'h0000;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0, rdat;
  logic [7:0]  good = 8'h00, m, vld, k285, stat;
  logic [7:0]  expq[$]; // Expected read bytes, oldest first
  int          fail_count = 0, checked = 0, seed = 5697, ncyc = 0;

  always #50 clk_i = ~clk_i;

  slb_link_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .serial_lane_input_valid_i(vld), .serial_lane_input_k285_i(k285),
    .serial_lane_input_err_i(8'h00), .serial_lane_input_frame_i(stat),
    .serial_lane_input_cksum_i(stat), .serial_lane_input_ilas_i(stat),
    .sysref_i(sysref), .link0_sync_request_out_o(sr0),
    .link1_sync_request_out_o(sr1), .irq_o(irq));

  slb_tx_model far (.clk_i(clk_i), .k_i(k), .good_i(good), .sref_i(sref),
    .vld_o(vld), .k285_o(k285), .stat_o(stat), .sysref_o(sysref));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic end_sim;
    if (fail_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Classic cycle: hold everything until ack is sampled high
  // No wait limit here; only the bench timeout ends a hung cycle
  task automatic bus(input logic w, input slb_idx_t a, input logic [7:0] d);
    @(posedge clk_i);
    {cyc, stb, we, sel} <= {1'b1, 1'b1, w, 4'hF};
    adr <= {2'b00, a, 2'b00};
    dat <= {24'h0, d};
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    {cyc, stb, we} <= 3'b000;
  endtask

  task automatic rd(input slb_idx_t a, input logic [7:0] e);
    expq.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask

  // Burst of n K28.5 characters, then data
  task automatic kburst(input int n);
    @(posedge clk_i);
    k <= 1'b1;
    repeat (n) @(posedge clk_i);
    k <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask

  // Read results compared as they appear; hang guard
  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0)
      check("read data", expq.pop_front(), rdat[7:0]);
    if (++ncyc > 3000) begin
      fail_count++;
      end_sim();
    end
  end

  // ****************************************************************
  // Bring-up sequence
  // ****************************************************************
  initial begin
    m = 8'($random(seed));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(IDX_MF_DLY_A, 8'h00);
    bus(1'b1, IDX_MF_DLY_A, 8'h00);
    bus(1'b1, IDX_MF_DLY_B, 8'h00);
    bus(1'b1, IDX_RXB_DLY_A, 8'h0A);
    bus(1'b1, IDX_RXB_DLY_B, 8'h0A);
    bus(1'b1, IDX_SUBCLASS, m);
    rd(IDX_MF_DLY_B, 8'h00);
    rd(IDX_RXB_DLY_A, 8'h0A);
    rd(IDX_RXB_DLY_B, 8'h0A);
    rd(IDX_SUBCLASS, m);
    bus(1'b1, IDX_SYNC_CTRL, 8'h01);
    rd(IDX_SYNC_STAT, 8'h01);
    bus(1'b1, IDX_SYNC_CTRL, 8'h81);
    rd(IDX_SYNC_STAT, 8'h02);
    bus(1'b1, IDX_SYNC_CTRL, 8'hC1);
    rd(IDX_SYNC_STAT, 8'h04);
    @(posedge clk_i);
    sref <= 1'b1;
    repeat (6) @(posedge clk_i);
    sref <= 1'b0;
    rd(IDX_SYNC_STAT, 8'h08);
    rd(IDX_SYNC_CTRL, 8'h81);
    bus(1'b1, IDX_LINK_CTL, 8'h0B);
    rd(IDX_LINK_CTL, 8'h0B);
    kburst(3);
    rd(IDX_CGS_STAT, 8'h00);
    check("link0 sync request", 8'h00, {7'h0, sr0});
    kburst(4);
    check("link0 sync request", 8'h01, {7'h0, sr0});
    check("link1 sync request", 8'h01, {7'h0, sr1});
    rd(IDX_CGS_STAT, 8'h0F);
    rd(IDX_FRM_STAT, 8'h00);
    good <= m;
    // Model and status flops each add a cycle before a read sees it
    repeat (3) @(posedge clk_i);
    for (int i = 1; i < 4; i++)
      rd(slb_idx_t'(IDX_CGS_STAT + i), {4'h0, m[3:0]});
    bus(1'b1, IDX_LINK_CTL, 8'h0F);
    rd(IDX_CGS_STAT, 8'h0F);
    for (int i = 1; i < 4; i++)
      rd(slb_idx_t'(IDX_CGS_STAT + i), {4'h0, m[7:4]});
    check("irq masked", 8'h00, {7'h0, irq});
    bus(1'b1, IDX_IRQ_MASK, 8'h1F);
    repeat (3) @(posedge clk_i);
    check("irq raised", 8'h01, {7'h0, irq});
    rd(IDX_IRQ_STAT, 8'h13);
    repeat (3) @(posedge clk_i);
    check("irq cleared", 8'h00, {7'h0, irq});
    rd(IDX_IRQ_STAT, 8'h00);
    // Disabling both links drops lane sync and flags the loss
    bus(1'b1, IDX_LINK_CTL, 8'h00);
    repeat (2) @(posedge clk_i);
    check("link0 sync request", 8'h00, {7'h0, sr0});
    check("link1 sync request", 8'h00, {7'h0, sr1});
    rd(IDX_IRQ_STAT, 8'h0C);
    rd(12'h123, 8'h00);
    repeat (3) @(posedge clk_i);
    end_sim();
  end
endmodule
